// ==== hw/psd_top.sv ====
`timescale 1ns/100ps
`include "psd_params.svh"

module psd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire psd_pkg::psd_straps_t strap_pins,
	input wire logic ee_present,
	input wire logic ee_valid,
	input wire psd_pkg::psd_straps_t ee_straps,
	input wire logic ee_done,
	input wire logic van_fail,
	input wire logic van_speed_100,
	output logic port0_speed_100,
	output logic straps_ready
);
	import psd_pkg::*;

	psd_state_t state;
	psd_state_t next_state;
	psd_straps_t strap_sync;
	logic setup;
	logic done;
	logic was_load;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// register bit defaults derived from the straps
	function automatic psd_regs_t strap_defaults(input psd_straps_t s);
		psd_regs_t r;
		logic ten;
		r = '0;
		ten = s.p2_an | ~s.p2_speed;
		r.autoneg_enable_bit = s.p2_an;
		r.speed_select_low_bit = s.p2_an | s.p2_speed;
		r.duplex_mode_bit = s.p2_an | s.p2_duplex;
		r.adv_10hd = ten;
		r.adv_10fd = ten & s.p2_duplex;
		r.mode = s.p2_an ? `PSD_MODE_AN : {1'b0, s.p2_speed, s.p2_duplex};
		r.port2_backpressure_enable = s.p2_bp;
		r.port2_tx_pause_enable = s.p2_fd_pause;
		r.port2_rx_pause_enable = s.p2_fd_pause;
		r.port2_manual_pause_select = s.p2_manual;
		r.adv_sym = ~s.p2_manual;
		r.adv_asym = s.p2_fd_pause & ~s.p2_manual;
		r.vp_100fd = s.p0_speed;
		r.vp_100hd = s.p0_speed;
		r.vp_10fd = 1'b1;
		r.vp_10hd = 1'b1;
		return r;
	endfunction : strap_defaults

	// true for every mapped offset
	function automatic logic addr_known(input logic [7:0] a);
		case (a)
			`PSD_OFF_BASIC, `PSD_OFF_ADV, `PSD_OFF_MODES, `PSD_OFF_FLOW,
			`PSD_OFF_VPART, `PSD_OFF_STATUS, `PSD_OFF_CTRL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : addr_known

	// read data for an offset
	function automatic logic [31:0] rd_word(input psd_state_t s,
		input logic [7:0] a);
		logic [31:0] w;
		w = `PSD_RDATA_IDLE;
		case (a)
			`PSD_OFF_BASIC: begin
				w[`PSD_BC_AN] = s.regs.autoneg_enable_bit;
				w[`PSD_BC_SPEED] = s.regs.speed_select_low_bit;
				w[`PSD_BC_DUPLEX] = s.regs.duplex_mode_bit;
			end
			`PSD_OFF_ADV: begin
				w[`PSD_ADV_10HD] = s.regs.adv_10hd;
				w[`PSD_ADV_10FD] = s.regs.adv_10fd;
				w[`PSD_ADV_SYM] = s.regs.adv_sym;
				w[`PSD_ADV_ASYM] = s.regs.adv_asym;
			end
			`PSD_OFF_MODES: w[`PSD_MODE_MSB:`PSD_MODE_LSB] = s.regs.mode;
			`PSD_OFF_FLOW: begin
				w[`PSD_FC_BP] = s.regs.port2_backpressure_enable;
				w[`PSD_FC_RX] = s.regs.port2_rx_pause_enable;
				w[`PSD_FC_TX] = s.regs.port2_tx_pause_enable;
				w[`PSD_FC_MAN] = s.regs.port2_manual_pause_select;
			end
			`PSD_OFF_VPART: begin
				w[`PSD_VP_10HD] = s.regs.vp_10hd;
				w[`PSD_VP_10FD] = s.regs.vp_10fd;
				w[`PSD_VP_100HD] = s.regs.vp_100hd;
				w[`PSD_VP_100FD] = s.regs.vp_100fd;
			end
			`PSD_OFF_STATUS: begin
				w[`PSD_ST_STRAP_MSB:0] = s.straps;
				w[`PSD_ST_READY] = s.ready;
				w[`PSD_ST_P0SPEED] = s.port0_speed_100;
			end
			default: w = `PSD_RDATA_IDLE;
		endcase
		return w;
	endfunction : rd_word

	// ---------------------------------------------------------------
	// strap pin synchroniser
	// ---------------------------------------------------------------
	psd_strap_sync #(
		.W($bits(psd_straps_t))
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(strap_pins),
		.dout(strap_sync)
	);

	// apb phase decode
	assign setup = psel & ~penable;
	assign done = psel & penable & state.pready;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		// strap capture and loader sequence
		unique case (state.phase)
			PH_SETTLE: begin
				if (state.settle == `PSD_SETTLE_LAST) begin
					next_state.straps = strap_sync;
					next_state.phase = PH_LOAD;
				end else begin
					next_state.settle = state.settle + 2'h1;
				end
			end
			PH_LOAD: begin
				if (ee_present && ee_valid) begin
					next_state.straps = ee_straps;
				end
				if (!ee_present || ee_done) begin
					// defaults applied here and again on a CTRL reload, straps frozen after
					next_state.regs = strap_defaults(next_state.straps);
					next_state.phase = PH_RUN;
					next_state.ready = 1'b1;
				end
			end
			PH_RUN: begin
				next_state.phase = PH_RUN;
			end
		endcase
		// port 0 speed falls back to its strap
		next_state.port0_speed_100 = van_fail ? state.straps.p0_speed
			: van_speed_100;
		// answer one cycle after setup, held off until running
		next_state.pready = psel & (state.phase == PH_RUN) & ~done;
		if (next_state.pready && !state.pready) begin
			next_state.prdata = rd_word(state, paddr);
			next_state.pslverr = ~addr_known(paddr);
		end
		// register writes take effect at completion
		if (done && pwrite) begin
			case (paddr)
				`PSD_OFF_BASIC: begin
					next_state.regs.autoneg_enable_bit = pwdata[`PSD_BC_AN];
					next_state.regs.speed_select_low_bit = pwdata[`PSD_BC_SPEED];
					next_state.regs.duplex_mode_bit = pwdata[`PSD_BC_DUPLEX];
				end
				`PSD_OFF_ADV: begin
					next_state.regs.adv_10hd = pwdata[`PSD_ADV_10HD];
					next_state.regs.adv_10fd = pwdata[`PSD_ADV_10FD];
					next_state.regs.adv_sym = pwdata[`PSD_ADV_SYM];
					next_state.regs.adv_asym = pwdata[`PSD_ADV_ASYM];
				end
				`PSD_OFF_MODES: begin
					next_state.regs.mode = pwdata[`PSD_MODE_MSB:`PSD_MODE_LSB];
				end
				`PSD_OFF_FLOW: begin
					next_state.regs.port2_backpressure_enable = pwdata[`PSD_FC_BP];
					next_state.regs.port2_rx_pause_enable = pwdata[`PSD_FC_RX];
					next_state.regs.port2_tx_pause_enable = pwdata[`PSD_FC_TX];
					next_state.regs.port2_manual_pause_select = pwdata[`PSD_FC_MAN];
				end
				`PSD_OFF_VPART: begin
					next_state.regs.vp_10hd = pwdata[`PSD_VP_10HD];
					next_state.regs.vp_10fd = pwdata[`PSD_VP_10FD];
					next_state.regs.vp_100hd = pwdata[`PSD_VP_100HD];
					next_state.regs.vp_100fd = pwdata[`PSD_VP_100FD];
				end
				`PSD_OFF_CTRL: begin
					// soft reset of the strap-derived bits
					if (pwdata[`PSD_CTRL_RELOAD]) begin
						next_state.regs = strap_defaults(state.straps);
					end
				end
				default: next_state.regs = state.regs;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state flops
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign port0_speed_100 = state.port0_speed_100;
	assign straps_ready = state.ready;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign was_load = (state.phase == PH_LOAD) && (next_state.phase == PH_RUN);

	AST_AN_DEFAULT: assert property (
		was_load |=> state.regs.autoneg_enable_bit == state.straps.p2_an)
		else $error("autoneg enable default wrong");
	AST_AN_MODE: assert property (
		was_load ##1 state.straps.p2_an |-> state.regs.mode == `PSD_MODE_AN
			&& state.regs.adv_10hd && state.regs.speed_select_low_bit)
		else $error("autoneg strap did not shape defaults");
	AST_SPEED_DEFAULT: assert property (
		was_load ##1 !state.straps.p2_an |-> state.regs.speed_select_low_bit
			== state.straps.p2_speed && state.regs.mode[1]
			== state.straps.p2_speed)
		else $error("speed strap default wrong");
	AST_DUPLEX_DEFAULT: assert property (
		was_load ##1 !state.straps.p2_an |-> state.regs.duplex_mode_bit
			== state.straps.p2_duplex && state.regs.mode[0]
			== state.straps.p2_duplex)
		else $error("duplex strap default wrong");
	AST_BP_DEFAULT: assert property (
		was_load |=> state.regs.port2_backpressure_enable
			== $past(next_state.straps.p2_bp))
		else $error("backpressure default wrong");
	AST_PAUSE_DEFAULT: assert property (
		was_load |=> state.regs.port2_tx_pause_enable == state.straps.p2_fd_pause
			&& state.regs.port2_rx_pause_enable == state.straps.p2_fd_pause)
		else $error("pause enable defaults wrong");
	AST_ASYM_ADV: assert property (
		was_load ##1 !state.straps.p2_fd_pause |-> !state.regs.adv_asym)
		else $error("asym pause advertised without fd pause strap");
	AST_MANUAL_DEFAULT: assert property (
		was_load |=> state.regs.port2_manual_pause_select
			== state.straps.p2_manual)
		else $error("manual pause default wrong");
	AST_MANUAL_ADV: assert property (
		was_load ##1 state.straps.p2_manual |-> !state.regs.adv_sym
			&& !state.regs.adv_asym)
		else $error("pause advertised under manual pause");
	AST_VPART_DEFAULT: assert property (
		was_load |=> state.regs.vp_100fd == state.straps.p0_speed
			&& state.regs.vp_100hd == state.straps.p0_speed
			&& state.regs.vp_10fd && state.regs.vp_10hd)
		else $error("virtual partner ability default wrong");
	AST_P0_FALLBACK: assert property (
		van_fail |=> port0_speed_100 == $past(state.straps.p0_speed))
		else $error("port 0 fallback speed wrong");
	AST_EE_REPLACE: assert property (
		state.phase == PH_LOAD && ee_present && ee_valid
			|=> state.straps == $past(ee_straps))
		else $error("eeprom value not taken");
	AST_STRAP_HOLD: assert property (
		state.phase == PH_RUN |=> $stable(state.straps)
			&& state.phase == PH_RUN)
		else $error("straps changed while running");
	AST_APB_ANSWER: assert property (
		setup && state.phase == PH_RUN |=> pready)
		else $error("no zero wait answer while running");

endmodule : psd_top

// ==== hw/psd_params.svh ====
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PSD_OFF_BASIC 8'h00
`define PSD_OFF_ADV 8'h04
`define PSD_OFF_MODES 8'h08
`define PSD_OFF_FLOW 8'h0C
`define PSD_OFF_VPART 8'h10
`define PSD_OFF_STATUS 8'h14
`define PSD_OFF_CTRL 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PSD_BC_DUPLEX 8
`define PSD_BC_AN 12
`define PSD_BC_SPEED 13
`define PSD_ADV_10HD 5
`define PSD_ADV_10FD 6
`define PSD_ADV_SYM 10
`define PSD_ADV_ASYM 11
`define PSD_MODE_LSB 5
`define PSD_MODE_MSB 7
`define PSD_FC_BP 0
`define PSD_FC_RX 1
`define PSD_FC_TX 2
`define PSD_FC_MAN 3
`define PSD_VP_10HD 5
`define PSD_VP_10FD 6
`define PSD_VP_100HD 7
`define PSD_VP_100FD 8
`define PSD_ST_STRAP_MSB 6
`define PSD_ST_READY 8
`define PSD_ST_P0SPEED 9
`define PSD_CTRL_RELOAD 0

// ---------------------------------------------------------------
// values and counts
// ---------------------------------------------------------------
// strap defaults: an, speed, duplex, bp, fd pause, manual, p0 speed
`define PSD_STRAP_DEFAULTS 7'h77
`define PSD_MODE_AN 3'h7
`define PSD_SETTLE_LAST 2'h2
`define PSD_RDATA_IDLE 32'h0000_0000

`endif

// ==== hw/psd_pkg.sv ====
package psd_pkg;

	// captured soft-strap values
	typedef struct packed {
		logic p2_an;
		logic p2_speed;
		logic p2_duplex;
		logic p2_bp;
		logic p2_fd_pause;
		logic p2_manual;
		logic p0_speed;
	} psd_straps_t;

	// register bits whose reset values follow the straps, except vp_10fd and vp_10hd, which are fixed at 1
	typedef struct packed {
		logic autoneg_enable_bit;
		logic speed_select_low_bit;
		logic duplex_mode_bit;
		logic adv_10hd;
		logic adv_10fd;
		logic adv_sym;
		logic adv_asym;
		logic [2:0] mode;
		logic port2_backpressure_enable;
		logic port2_tx_pause_enable;
		logic port2_rx_pause_enable;
		logic port2_manual_pause_select;
		logic vp_100fd;
		logic vp_100hd;
		logic vp_10fd;
		logic vp_10hd;
	} psd_regs_t;

	typedef enum logic [1:0] {
		PH_SETTLE,
		PH_LOAD,
		PH_RUN
	} psd_phase_t;

	typedef struct packed {
		psd_phase_t phase;
		logic [1:0] settle;
		psd_straps_t straps;
		psd_regs_t regs;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic port0_speed_100;
		logic ready;
	} psd_state_t;

endpackage : psd_pkg

// ==== hw/psd_strap_sync.sv ====
`timescale 1ns/100ps

// two-stage synchroniser for the strap pins
module psd_strap_sync #(
	parameter int W = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	import psd_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} psd_sync_t;

	psd_sync_t state;
	psd_sync_t next_state;

	// first stage feeds only the second
	always_comb begin
		next_state = state;
		next_state.s1 = din;
		next_state.s2 = state.s1;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign dout = state.s2;

endmodule : psd_strap_sync

// ==== bench/psd_strap_model.sv ====
`timescale 1ns/100ps

// board strap pins plus a serial loader that replays its own strap image
module psd_strap_model
	import psd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire psd_pkg::psd_straps_t pins,
	input wire logic use_ee,
	input wire psd_pkg::psd_straps_t ee_val,
	input wire logic [1:0] ee_wait,
	output psd_pkg::psd_straps_t strap_pins,
	output logic ee_present,
	output logic ee_valid,
	output psd_pkg::psd_straps_t ee_straps,
	output logic ee_done
);
	int cnt;
	logic fire;

	// pins are static board levels; loader presence is a board option
	assign strap_pins = pins;
	assign ee_present = use_ee;
	assign fire = use_ee && (cnt == 5 + int'(ee_wait));

	// one image word late in load, then done; data churns when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			ee_valid <= 1'b0;
			ee_done <= 1'b0;
			ee_straps <= ~ee_val;
		end else begin
			cnt <= cnt + 1;
			ee_valid <= fire;
			ee_done <= ee_valid;
			ee_straps <= fire ? ee_val : ~ee_straps;
		end
	end
endmodule : psd_strap_model

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`include "psd_params.svh"

module tb;
	import psd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, seed, x;
	logic e, ee_present, ee_valid, ee_done, van_fail, van_speed_100;
	logic port0_speed_100, straps_ready, use_ee;
	logic [1:0] ee_wait;
	psd_straps_t pins, strap_pins, ee_val, ee_straps, s;
	int num_errors, samples_checked, n;

	psd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.strap_pins(strap_pins), .ee_present(ee_present),
		.ee_valid(ee_valid), .ee_straps(ee_straps), .ee_done(ee_done),
		.van_fail(van_fail), .van_speed_100(van_speed_100),
		.port0_speed_100(port0_speed_100), .straps_ready(straps_ready));
	psd_strap_model MDL (.pclk(pclk), .presetn(presetn), .pins(pins),
		.use_ee(use_ee), .ee_val(ee_val), .ee_wait(ee_wait),
		.strap_pins(strap_pins), .ee_present(ee_present),
		.ee_valid(ee_valid), .ee_straps(ee_straps), .ee_done(ee_done));

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// expected register word for a given strap set
	function automatic logic [31:0] exp_reg(input logic [7:0] a,
		input psd_straps_t t, input logic p0);
		logic an, ten;
		logic [31:0] v;
		an = t.p2_an;
		ten = an | ~t.p2_speed;
		v = 32'h0000_0000;
		case (a)
			`PSD_OFF_BASIC: v[13:8] = {an | t.p2_speed, an, 3'h0, an | t.p2_duplex};
			`PSD_OFF_ADV: v[11:5] = {t.p2_fd_pause & ~t.p2_manual,
				~t.p2_manual, 3'h0, ten & t.p2_duplex, ten};
			`PSD_OFF_MODES: v[7:5] = an ? 3'h7 : {1'b0, t.p2_speed, t.p2_duplex};
			`PSD_OFF_FLOW: v[3:0] = {t.p2_manual, t.p2_fd_pause,
				t.p2_fd_pause, t.p2_bp};
			`PSD_OFF_VPART: v[8:5] = {t.p0_speed, t.p0_speed, 2'h3};
			`PSD_OFF_STATUS: v[9:0] = {p0, 1'b1, 1'b0, t};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : exp_reg

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want) begin
			$display("unexpected at %0t: got %h want %h", $time, got, want);
			num_errors++;
		end
	endtask : chk

	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (k >= 100) chk(32'h1, 32'h0);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// read one mapped word, compare it with the defaults of s, no error
	task automatic rd_chk(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk(r, exp_reg(a, s, s.p0_speed));
		chk({31'h0, e}, 32'h0);
	endtask : rd_chk

	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	// -------------------------------------------------------------
	// clock, watchdog and main sequence
	// -------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		#200000;
		num_errors++;
		final_report();
	end

	initial begin
		{psel, penable, pwrite, presetn, use_ee, van_speed_100} = '0;
		{paddr, pwdata, ee_wait} = '0;
		van_fail = 1'b1;
		seed = 32'd44837;
		pins = 7'h77;
		ee_val = 7'h00;
		num_errors = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		// reset with assorted straps, with and without the loader
		for (int it = 0; it < 10; it++) begin
			presetn <= 1'b0;
			x = xs();
			pins <= (it == 0) ? 7'h77 : (it == 1) ? 7'h00 : x[6:0];
			use_ee <= (it == 3) || ((it > 3) && x[7]);
			ee_val <= x[14:8];
			ee_wait <= x[17:16];
			repeat (3) @(posedge pclk);
			presetn <= 1'b1;
			n = 0;
			while (straps_ready !== 1'b1 && n < 100) begin
				@(posedge pclk);
				n++;
			end
			// ready seen 5 edges after release, later with the loader
			chk(n, use_ee ? 9 + ee_wait : 5);
			s = use_ee ? ee_val : pins;
			rd_chk(`PSD_OFF_BASIC);
			rd_chk(`PSD_OFF_ADV);
			rd_chk(`PSD_OFF_MODES);
			rd_chk(`PSD_OFF_FLOW);
			rd_chk(`PSD_OFF_VPART);
			rd_chk(`PSD_OFF_STATUS);
		end
		// pins move after run: captured values must not follow
		pins <= ~s;
		repeat (6) @(posedge pclk);
		apb(1'b0, `PSD_OFF_STATUS, 32'h0);
		chk(r, exp_reg(`PSD_OFF_STATUS, s, s.p0_speed));
		apb(1'b1, `PSD_OFF_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, `PSD_OFF_STATUS, 32'h0);
		chk(r, exp_reg(`PSD_OFF_STATUS, s, s.p0_speed));
		// defaults are only reset values: software may overwrite them
		x = ~exp_reg(`PSD_OFF_FLOW, s, 1'b0) & 32'h0000_000F;
		apb(1'b1, `PSD_OFF_FLOW, x);
		apb(1'b0, `PSD_OFF_FLOW, 32'h0);
		chk(r, x);
		apb(1'b1, `PSD_OFF_CTRL, 32'h0000_0001);
		apb(1'b0, `PSD_OFF_FLOW, 32'h0);
		chk(r, exp_reg(`PSD_OFF_FLOW, s, 1'b0));
		// port 0 speed falls back to its strap on failed negotiation
		van_speed_100 <= ~s.p0_speed;
		repeat (3) @(posedge pclk);
		chk(port0_speed_100, s.p0_speed);
		van_fail <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(port0_speed_100, {31'h0, ~s.p0_speed});
		// unmapped word reads zero with an error
		apb(1'b0, 8'h1C, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		final_report();
	end
endmodule : tb
